// file: core/cib_bit_timer.sv
// Time quantum prescaler and nominal bit time sequencer
`timescale 1ns/1ns
module cib_bit_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Configuration
   input wire logic run_i,
   input wire logic [7:0] prescale_i,
   input wire logic [1:0] sjw_i,
   input wire logic [3:0] seg1_i,
   input wire logic [2:0] seg2_i,
   // Recessive to dominant edge on the bus
   input wire logic edge_i,
   // Timing pulses
   output logic tq_tick_o,
   output logic sample_o,
   output logic bit_start_o
);
   logic [7:0] pres_q, pres_d;
   logic [4:0] cnt_q, cnt_d, l1_q, l1_d, l2_q, l2_d;
   cib_pkg::cib_phase_t ph_q, ph_d;
   logic pend_q, samp_d, bs_d;

   // Quantum clock is the module clock divided by prescale plus one
   wire pres_end = (pres_q == prescale_i);
   wire tick = run_i & pres_end;
   assign pres_d = (!run_i || pres_end) ? 8'h00 : pres_q + 8'h01;

   wire [4:0] seg1_len = {1'b0, seg1_i} + 5'h01;
   wire [4:0] seg2_len = {2'h0, seg2_i} + 5'h01;
   wire [4:0] sjw_len = {3'h0, sjw_i} + 5'h01;
   wire [4:0] cnt_inc = cnt_q + 5'h01;
   wire [4:0] remain = l2_q - cnt_inc;
   // An edge seen between quanta is held until the next quantum
   wire pend = pend_q | edge_i;

   always_comb begin
      ph_d = ph_q;
      cnt_d = cnt_q;
      l1_d = l1_q;
      l2_d = l2_q;
      samp_d = 1'b0;
      bs_d = 1'b0;
      if (!run_i) begin
         ph_d = cib_pkg::PH_SYNC;
         cnt_d = 5'h00;
      end else if (tick) begin
         cnt_d = cnt_inc;
         case (ph_q)
            cib_pkg::PH_SYNC: begin
               // Sync segment is always one quantum
               ph_d = cib_pkg::PH_SEG1;
               cnt_d = 5'h00;
               l1_d = seg1_len;
               l2_d = seg2_len;
            end
            cib_pkg::PH_SEG1: begin
               // Late edge: lengthen segment one once by the jump width
               if (pend && l1_q == seg1_len) begin
                  l1_d = l1_q + sjw_len;
               end
               if (cnt_inc >= l1_d) begin
                  ph_d = cib_pkg::PH_SEG2;
                  cnt_d = 5'h00;
                  samp_d = 1'b1;
               end
            end
            cib_pkg::PH_SEG2: begin
               if (pend && remain <= sjw_len) begin
                  // Early edge close to the end: restart the bit here
                  ph_d = cib_pkg::PH_SEG1;
                  cnt_d = 5'h00;
                  l1_d = seg1_len;
                  l2_d = seg2_len;
                  bs_d = 1'b1;
               end else begin
                  if (pend) begin
                     l2_d = l2_q - sjw_len;
                  end
                  if (cnt_inc >= l2_d) begin
                     ph_d = cib_pkg::PH_SYNC;
                     bs_d = 1'b1;
                  end
               end
            end
            default: begin
               ph_d = cib_pkg::PH_SYNC;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pres_q <= 8'h00;
         cnt_q <= 5'h00;
         l1_q <= 5'h00;
         l2_q <= 5'h00;
         ph_q <= cib_pkg::PH_SYNC;
      end else begin
         pres_q <= pres_d;
         cnt_q <= cnt_d;
         l1_q <= l1_d;
         l2_q <= l2_d;
         ph_q <= ph_d;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend_q <= 1'b0;
         tq_tick_o <= 1'b0;
         sample_o <= 1'b0;
         bit_start_o <= 1'b0;
      end else begin
         pend_q <= pend & ~tick & run_i;
         tq_tick_o <= tick;
         sample_o <= samp_d;
         bit_start_o <= bs_d;
      end
   end
endmodule // cib_bit_timer

// file: core/cib_pkg.sv
// Constants and types shared by the CAN interrupt and bit timing register block
package cib_pkg;
   // APB address width; byte address is four times a register index
   localparam int ADDR_W = 18;

   // Register indices
   localparam logic [15:0] IE_IDX = 16'hFF96;
   localparam logic [15:0] IS_IDX = 16'hFF98;
   localparam logic [15:0] QP_IDX = 16'hFF9A;
   localparam logic [15:0] BT_IDX = 16'hFF9C;
   localparam logic [15:0] LP_IDX = 16'hFF9E;
   localparam logic [15:0] CT_IDX = 16'hFFA0;
   localparam logic [15:0] RH_IDX = 16'hFFA2;

   // Interrupt source positions
   localparam int N_SRC = 6;
   localparam int IE_SET_LSB = 8;
   localparam int SRC_WAKE = 5;
   localparam int SRC_ARB = 4;
   localparam int SRC_PERR = 3;
   localparam int SRC_ESTAT = 2;
   localparam int SRC_RX = 1;
   localparam int SRC_TX = 0;

   // Bit timing and control field positions
   localparam int BT_SEG1_LSB = 0;
   localparam int BT_SEG2_LSB = 8;
   localparam int BT_SJW_LSB = 12;
   localparam int CT_INIT = 0;
   localparam int CT_SLEEP = 1;

   // Values after reset
   localparam logic [5:0] IE_RST = 6'h00;
   localparam logic [5:0] IS_RST = 6'h00;
   localparam logic [7:0] QP_RST = 8'hFF;
   localparam logic [3:0] SEG1_RST = 4'hF;
   localparam logic [2:0] SEG2_RST = 3'h7;
   localparam logic [1:0] SJW_RST = 2'h3;

   // Phases of one nominal bit time
   typedef enum logic [1:0] {
      PH_SYNC = 2'b00,
      PH_SEG1 = 2'b01,
      PH_SEG2 = 2'b10
   } cib_phase_t;
endpackage

// file: core/cib_regs.sv
// APB register block: CAN interrupts, prescaler, bit timing, receive history
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////

// What this block does
// - A pending source reaches the interrupt only while its enable bit is 1.
// - Enable write: set-only sets, clear-only clears, other pairs leave unchanged.
// - Status bit reads 1 while its source event is pending, else 0.
// - Writing 1 to status bits 5..0 clears them; upper bits read zero.
// - Status bits never clear themselves; software clears them explicitly.
// - Bits: 5 wake, 4 arbitration, 3 protocol error, 2 error state, 1 rx, 0 tx.
// - Wake status sets only on bus wakeup, not on software sleep release.
// - Status register at index FF98, zero after reset.
// - Quantum clock is module clock divided by prescale plus one; reset 255.
// - Prescaler accepts writes only in initialization mode.
// - Jump width code k gives k plus one quanta; reset four.
// - Second segment code k gives k plus one quanta; reset eight.
// - First segment code k gives k plus one quanta; code zero prohibited.
// - Last-stored pointer reads history entry one before the last-in pointer.
// - Last-stored value is meaningless before any store or when list empty.
// - Enable register at index FF96, read and write, zero after reset.
// - Receive-list-empty reads 1 when all history entries are read, else 0.
module cib_regs #(
   parameter int HIST_DEPTH = 8
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,

   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [cib_pkg::ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,

   // Protocol engine events, one-cycle pulses
   input wire logic TX_DONE_I,
   input wire logic RX_STORED_I,
   input wire logic [3:0] RX_BUF_NUM_I,
   input wire logic ESTAT_CHG_I,
   input wire logic PROTO_ERR_I,
   input wire logic ARB_LOSS_I,

   // CAN receive pin from the transceiver
   input wire logic CAN_RX_I,

   // Mode, interrupt and timing outputs
   output logic INIT_MODE_O,
   output logic SLEEP_O,
   output logic IRQ_O,
   output logic TQ_TICK_O,
   output logic SAMPLE_O,
   output logic BIT_START_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Local types and helpers

   localparam int IW = $clog2(HIST_DEPTH);
   localparam logic [IW-1:0] LAST = IW'(HIST_DEPTH - 1);
   localparam logic [IW:0] FULL = (IW + 1)'(HIST_DEPTH);

   function automatic logic hit(
      input logic [cib_pkg::ADDR_W-1:0] a,
      input logic [15:0] idx
   );
      hit = (a == {idx, 2'h0});
   endfunction

   // History pointers wrap at any depth, not only powers of two
   function automatic logic [IW-1:0] nxt(input logic [IW-1:0] p);
      nxt = (p == LAST) ? {IW{1'b0}} : p + 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic rx_s1_q;
   logic rx_s2_q;
   logic rx_s3_q;
   logic pready_q;
   logic slverr_q;
   logic [31:0] prdata_q;
   logic [5:0] en_q, en_d;
   logic [5:0] st_q, st_d;
   logic [7:0] qp_q, qp_d;
   logic [3:0] seg1_q, seg1_d;
   logic [2:0] seg2_q, seg2_d;
   logic [1:0] sjw_q, sjw_d;
   logic init_q, init_d;
   logic sleep_q, sleep_d;
   logic irq_q;
   logic [IW-1:0] lip_q, lip_d;
   logic [IW-1:0] gp_q, gp_d;
   logic [IW:0] cnt_q, cnt_d;
   logic [3:0] hist_mem [HIST_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Bus pin synchroniser

   // Third stage only feeds the edge detector, never the first stage
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
      end else begin
         rx_s1_q <= CAN_RX_I;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   // Recessive to dominant transition
   wire fall = rx_s3_q & ~rx_s2_q;
   wire run = ~init_q & ~sleep_q;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   wire acc = PSEL_I & PENABLE_I;
   // One wait state so read data can come from a flop
   wire done = acc & pready_q;
   wire wr = done & PWRITE_I;
   wire rd = done & ~PWRITE_I;

   wire h_ie = hit(PADDR_I, cib_pkg::IE_IDX);
   wire h_is = hit(PADDR_I, cib_pkg::IS_IDX);
   wire h_qp = hit(PADDR_I, cib_pkg::QP_IDX);
   wire h_bt = hit(PADDR_I, cib_pkg::BT_IDX);
   wire h_lp = hit(PADDR_I, cib_pkg::LP_IDX);
   wire h_ct = hit(PADDR_I, cib_pkg::CT_IDX);
   wire h_rh = hit(PADDR_I, cib_pkg::RH_IDX);
   wire h_any = h_ie | h_is | h_qp | h_bt | h_lp | h_ct | h_rh;

   // Unstrobed lanes write as zero, which the set and clear bits ignore
   wire [15:0] lmask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
   wire [15:0] wd = PWDATA_I[15:0] & lmask;
   wire lo_wr = wr & PSTRB_I[0];
   wire hi_wr = wr & PSTRB_I[1];

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt enable and status

   wire [5:0] ie_set = wd[cib_pkg::IE_SET_LSB +: cib_pkg::N_SRC];
   wire [5:0] ie_clr = wd[cib_pkg::N_SRC-1:0];
   wire ie_wr = wr & h_ie;

   // Set alone sets, clear alone clears, both or neither keep the bit
   assign en_d = ie_wr ? ((en_q & ~(ie_clr & ~ie_set)) | (ie_set & ~ie_clr))
                       : en_q;

   wire wake_ev = sleep_q & fall;
   wire [5:0] ev;
   assign ev[cib_pkg::SRC_WAKE] = wake_ev;
   assign ev[cib_pkg::SRC_ARB] = ARB_LOSS_I;
   assign ev[cib_pkg::SRC_PERR] = PROTO_ERR_I;
   assign ev[cib_pkg::SRC_ESTAT] = ESTAT_CHG_I;
   assign ev[cib_pkg::SRC_RX] = RX_STORED_I;
   assign ev[cib_pkg::SRC_TX] = TX_DONE_I;

   wire [5:0] is_clr = (wr & h_is) ? wd[cib_pkg::N_SRC-1:0] : 6'h00;
   // A new event in the clearing cycle survives the clear
   assign st_d = (st_q & ~is_clr) | ev;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and bit timing

   wire qp_ok = lo_wr & h_qp & init_q;
   assign qp_d = qp_ok ? wd[7:0] : qp_q;

   wire [3:0] seg1_w = wd[cib_pkg::BT_SEG1_LSB +: 4];
   // A prohibited zero first-segment code is dropped, keeping a legal bit time
   wire seg1_ok = lo_wr & h_bt & (seg1_w != 4'h0);
   assign seg1_d = seg1_ok ? seg1_w : seg1_q;
   assign seg2_d = (hi_wr & h_bt) ? wd[cib_pkg::BT_SEG2_LSB +: 3] : seg2_q;
   assign sjw_d = (hi_wr & h_bt) ? wd[cib_pkg::BT_SJW_LSB +: 2] : sjw_q;

   ////////////////////////////////////////////////////////////////////////////
   // Operating mode

   wire ct_wr = lo_wr & h_ct;
   assign init_d = ct_wr ? wd[cib_pkg::CT_INIT] : init_q;

   // Sleep is only entered by a control write whose init bit is 0; a software release
   // drops it without touching the wake status bit
   always_comb begin
      sleep_d = sleep_q;
      if (wake_ev) begin
         sleep_d = 1'b0;
      end
      if (ct_wr) begin
         sleep_d = wd[cib_pkg::CT_SLEEP] & ~wd[cib_pkg::CT_INIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive history list

   wire leave_init = init_q & ~init_d;
   wire store = RX_STORED_I & ~init_q;
   wire empty = (cnt_q == {(IW + 1){1'b0}});
   wire take = rd & h_rh & ~empty;
   wire full = (cnt_q == FULL);
   wire [IW-1:0] lip_prev = (lip_q == {IW{1'b0}}) ? LAST : lip_q - 1'b1;
   // When full the newest entry is overwritten and the pointer stays
   wire [IW-1:0] wr_idx = full ? lip_prev : lip_q;

   always_comb begin
      lip_d = lip_q;
      gp_d = gp_q;
      cnt_d = cnt_q;
      if (leave_init) begin
         // List restarts empty, so the last-stored value is meaningless
         lip_d = {IW{1'b0}};
         gp_d = {IW{1'b0}};
         cnt_d = {(IW + 1){1'b0}};
      end else begin
         if (store && !full) begin
            lip_d = nxt(lip_q);
         end
         if (take) begin
            gp_d = nxt(gp_q);
         end
         if (store && !full && !take) begin
            cnt_d = cnt_q + 1'b1;
         end else if (take && !(store && !full)) begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   // Entries carry no reset; a read before any store is undefined
   always_ff @(posedge CLK_I) begin
      if (store) begin
         hist_mem[wr_idx] <= RX_BUF_NUM_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   wire [15:0] bt_rd = {2'h0, sjw_q, 1'h0, seg2_q, 4'h0, seg1_q};
   wire [15:0] ct_rd = {13'h0000, empty, sleep_q, init_q};
   wire [15:0] rh_rd = {4'h0, hist_mem[gp_q], 6'h00, empty, 1'h0};
   wire [15:0] lp_rd = {12'h000, hist_mem[lip_prev]};

   wire [15:0] rmux = h_ie ? {10'h000, en_q} :
                      h_is ? {10'h000, st_q} :
                      h_qp ? {8'h00, qp_q} :
                      h_bt ? bt_rd :
                      h_lp ? lp_rd :
                      h_ct ? ct_rd :
                      h_rh ? rh_rd :
                      16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // APB response flops

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc & ~pready_q;
         if (acc && !pready_q) begin
            slverr_q <= ~h_any;
            prdata_q <= PWRITE_I ? 32'h0000_0000 : {16'h0000, rmux};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and status flops

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         en_q <= cib_pkg::IE_RST;
         st_q <= cib_pkg::IS_RST;
      end else begin
         en_q <= en_d;
         st_q <= st_d;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         qp_q <= cib_pkg::QP_RST;
         seg1_q <= cib_pkg::SEG1_RST;
         seg2_q <= cib_pkg::SEG2_RST;
         sjw_q <= cib_pkg::SJW_RST;
      end else begin
         qp_q <= qp_d;
         seg1_q <= seg1_d;
         seg2_q <= seg2_d;
         sjw_q <= sjw_d;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         init_q <= 1'b1;
         sleep_q <= 1'b0;
      end else begin
         init_q <= init_d;
         sleep_q <= sleep_d;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         lip_q <= {IW{1'b0}};
         gp_q <= {IW{1'b0}};
         cnt_q <= {(IW + 1){1'b0}};
      end else begin
         lip_q <= lip_d;
         gp_q <= gp_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt output

   // Registered so the pin is glitch free; lags the status by one cycle
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(st_q & en_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit timing

   cib_bit_timer u_timer (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .run_i(run),
      .prescale_i(qp_q),
      .sjw_i(sjw_q),
      .seg1_i(seg1_q),
      .seg2_i(seg2_q),
      .edge_i(fall & run),
      .tq_tick_o(TQ_TICK_O),
      .sample_o(SAMPLE_O),
      .bit_start_o(BIT_START_O)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = slverr_q;
   assign INIT_MODE_O = init_q;
   assign SLEEP_O = sleep_q;
   assign IRQ_O = irq_q;

endmodule // cib_regs

// file: tb/can_irq_and_bit_timing_regs_tb_top.sv
// Self-checking testbench for the CAN interrupt and bit timing register block
`timescale 1ns/1ns
module can_irq_and_bit_timing_regs_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic wake = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [4:0] ev = 5'h00;
   logic [3:0] bufn = 4'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, irq, init_m, sleep_m, tick, smp, bst, can_rx;
   int errors = 0;
   int n_tests = 0;
   initial begin
      forever #10 clk = ~clk;
   end
   cib_regs DUT (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .TX_DONE_I(ev[0]), .RX_STORED_I(ev[1]),
      .RX_BUF_NUM_I(bufn), .ESTAT_CHG_I(ev[2]), .PROTO_ERR_I(ev[3]), .ARB_LOSS_I(ev[4]),
      .CAN_RX_I(can_rx), .INIT_MODE_O(init_m), .SLEEP_O(sleep_m), .IRQ_O(irq),
      .TQ_TICK_O(tick), .SAMPLE_O(smp), .BIT_START_O(bst));
   cib_can_node node (.clk_i(clk), .reset_n_i(rst_n), .wake_i(wake), .can_rx_o(can_rx));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Answer is taken at the edge that samples pready high, then released there
   task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
      xfer(1'b1, idx, wd);
   endtask
   task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp,
                      input logic [31:0] m = 32'hFFFFFFFF);
      xfer(1'b0, idx, 16'h0000);
      chk(nm, exp, rd & m);
   endtask
   task automatic pulse(input int i, input logic [3:0] b);
      @(posedge clk);
      ev <= 5'(1 << i);
      bufn <= b;
      @(posedge clk);
      ev <= 5'h00;
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return tick;
         1: return bst;
         2: return smp;
         3: return irq;
         4: return sleep_m;
         default: return init_m;
      endcase
   endfunction
   task automatic flag(input string nm, input int w, input logic exp);
      repeat (3) @(negedge clk);
      chk(nm, {31'h0, exp}, {31'h0, sig(w)});
   endtask
   // Cycles from a pulse on one timing output to the next pulse on the same or another
   task automatic gap(input string nm, input int a, input int b, input int exp);
      int n;
      n = 0;
      while (sig(a) !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (sig(b) !== 1'b1 && n < 600);
      chk(nm, exp, n);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdc("enable", cib_pkg::IE_IDX, 32'h00000000);
      rdc("status", cib_pkg::IS_IDX, 32'h00000000);
      rdc("prescale", cib_pkg::QP_IDX, 32'h000000FF);
      rdc("timing", cib_pkg::BT_IDX, 32'h0000370F);
      rdc("unmapped", 16'h0000, 32'h00000000);
      chk("slverr", 32'h00000001, {31'h0, err});
      // Prescale 3 with first segment 4 quanta stays clear of the undivided case
      wr(cib_pkg::QP_IDX, 16'h0003);
      wr(cib_pkg::BT_IDX, 16'h1203);
      wr(cib_pkg::BT_IDX, 16'h1200);
      rdc("timing", cib_pkg::BT_IDX, 32'h00001203);
      wr(cib_pkg::CT_IDX, 16'h0000);
      flag("init", 5, 1'b0);
      wr(cib_pkg::QP_IDX, 16'h0010);
      rdc("prescale", cib_pkg::QP_IDX, 32'h00000003);
      gap("quantum", 0, 0, 4);
      gap("bit time", 1, 1, 32);
      gap("seg two", 2, 1, 12);
      gap("sync seg one", 1, 2, 20);
      wr(cib_pkg::IE_IDX, 16'h3F00);
      rdc("enable", cib_pkg::IE_IDX, 32'h0000003F);
      wr(cib_pkg::IE_IDX, 16'h0101);
      rdc("enable", cib_pkg::IE_IDX, 32'h0000003F);
      wr(cib_pkg::IE_IDX, 16'h0003);
      rdc("enable", cib_pkg::IE_IDX, 32'h0000003C);
      wr(cib_pkg::IE_IDX, 16'h0000);
      rdc("enable", cib_pkg::IE_IDX, 32'h0000003C);
      wr(cib_pkg::IE_IDX, 16'h003F);
      for (int i = 0; i < 5; i++) begin
         pulse(i, 4'h9);
         rdc("status", cib_pkg::IS_IDX, 32'(1 << i));
         flag("irq", 3, 1'b0);
         wr(cib_pkg::IE_IDX, 16'(1 << (i + 8)));
         flag("irq", 3, 1'b1);
         wr(cib_pkg::IS_IDX, 16'h0000);
         rdc("status", cib_pkg::IS_IDX, 32'(1 << i));
         wr(cib_pkg::IS_IDX, 16'(1 << i));
         flag("irq", 3, 1'b0);
         wr(cib_pkg::IE_IDX, 16'(1 << i));
      end
      pulse(1, 4'h5);
      rdc("last stored", cib_pkg::LP_IDX, 32'h00000005, 32'h0000000F);
      rdc("list empty", cib_pkg::CT_IDX, 32'h00000000, 32'h00000004);
      rdc("history", cib_pkg::RH_IDX, 32'h00000900, 32'h00000F02);
      rdc("history", cib_pkg::RH_IDX, 32'h00000500, 32'h00000F02);
      rdc("list empty", cib_pkg::CT_IDX, 32'h00000004, 32'h00000004);
      wr(cib_pkg::IS_IDX, 16'h003F);
      wr(cib_pkg::IE_IDX, 16'h2000);
      wr(cib_pkg::CT_IDX, 16'h0002);
      flag("sleep", 4, 1'b1);
      wr(cib_pkg::CT_IDX, 16'h0000);
      rdc("status", cib_pkg::IS_IDX, 32'h00000000);
      wr(cib_pkg::CT_IDX, 16'h0002);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (12) @(posedge clk);
      flag("sleep", 4, 1'b0);
      rdc("status", cib_pkg::IS_IDX, 32'h00000020);
      flag("irq", 3, 1'b1);
      wr(cib_pkg::IE_IDX, 16'h003F);
      flag("irq", 3, 1'b0);
      wr(cib_pkg::IE_IDX, 16'h1000);
      pulse(4, 4'h0);
      flag("irq", 3, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      flag("init", 5, 1'b1);
      rdc("enable", cib_pkg::IE_IDX, 32'h00000000);
      rdc("status", cib_pkg::IS_IDX, 32'h00000000);
      close_out();
   end
endmodule // can_irq_and_bit_timing_regs_tb_top

// file: tb/cib_can_node.sv
// Far-side CAN node: idles recessive, sends a short dominant burst on request
`timescale 1ns/1ns
module cib_can_node (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Request a dominant burst
   input wire logic wake_i,
   // Bus level at the receiver, 1 is recessive
   output logic can_rx_o
);
   logic [3:0] dom_q;
   // Burst long enough to get through the receiver's synchroniser
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dom_q <= 4'h0;
      end else if (wake_i) begin
         dom_q <= 4'h8;
      end else if (dom_q != 4'h0) begin
         dom_q <= dom_q - 4'h1;
      end
   end
   // Termination pulls an idle bus back to recessive
   assign can_rx_o = (dom_q == 4'h0);
endmodule // cib_can_node

// file: tb/cib_regs_assertions.sv
// Concurrent checks on the ports of the CAN interrupt and bit timing register block
`timescale 1ns/1ns
module cib_regs_assertions #(
   parameter int HIST_DEPTH = 8
) (
   // Clock, reset and bus
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [cib_pkg::ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   // Events and outputs
   input wire logic TX_DONE_I,
   input wire logic RX_STORED_I,
   input wire logic ESTAT_CHG_I,
   input wire logic PROTO_ERR_I,
   input wire logic ARB_LOSS_I,
   input wire logic INIT_MODE_O,
   input wire logic SLEEP_O,
   input wire logic IRQ_O,
   input wire logic TQ_TICK_O,
   input wire logic SAMPLE_O,
   input wire logic BIT_START_O
);
   logic wr_done;
   logic ev_any;
   logic clr_all;
   logic [8:0] gap_q;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   assign wr_done = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
   assign ev_any = TX_DONE_I || RX_STORED_I || ESTAT_CHG_I || PROTO_ERR_I || ARB_LOSS_I;
   assign clr_all = wr_done && PADDR_I == {cib_pkg::IE_IDX, 2'b00}
      && PWDATA_I[13:8] == 6'h00 && PWDATA_I[5:0] == 6'h3F;
   // Quanta gap counter; slack covers the restart after leaving init mode
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         gap_q <= 9'h000;
      end else if (TQ_TICK_O || INIT_MODE_O || SLEEP_O) begin
         gap_q <= 9'h000;
      end else if (gap_q != 9'h1FF) begin
         gap_q <= gap_q + 9'h001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   ready_wait_a: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I)
      |-> !PREADY_O ##1 PREADY_O) else $error("bus answer not after one wait state");
   upper_zero_a: assert property (PREADY_O && !PWRITE_I
      |-> PRDATA_O[31:16] == 16'h0000) else $error("upper read data not zero");
   irq_reset_a: assert property ($rose(RESET_N_I) |-> !IRQ_O)
      else $error("interrupt high right after reset");
   irq_off_a: assert property (clr_all |-> ##2 !IRQ_O)
      else $error("interrupt stays high with all enables cleared");
   irq_hold_a: assert property (IRQ_O && !wr_done && !$past(wr_done) |=> IRQ_O)
      else $error("interrupt dropped without a register write");
   irq_cause_a: assert property ($rose(IRQ_O) |-> $past(ev_any, 2) || $past(wr_done, 2)
      || $past(SLEEP_O, 2) || $past(SLEEP_O, 3) || $past(SLEEP_O, 4))
      else $error("interrupt rose without a cause");
   tick_gap_a: assert property (gap_q < 9'h104)
      else $error("quantum tick missing for too long");
   init_quiet_a: assert property (INIT_MODE_O && $past(INIT_MODE_O)
      |-> !TQ_TICK_O && !BIT_START_O) else $error("bit timer running in init mode");
   sample_apart_a: assert property (SAMPLE_O |-> !BIT_START_O)
      else $error("sample point and bit start coincide");
endmodule // cib_regs_assertions

bind cib_regs cib_regs_assertions #(.HIST_DEPTH(HIST_DEPTH)) u_chk (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .TX_DONE_I(TX_DONE_I), .RX_STORED_I(RX_STORED_I),
   .ESTAT_CHG_I(ESTAT_CHG_I), .PROTO_ERR_I(PROTO_ERR_I), .ARB_LOSS_I(ARB_LOSS_I),
   .INIT_MODE_O(INIT_MODE_O), .SLEEP_O(SLEEP_O), .IRQ_O(IRQ_O), .TQ_TICK_O(TQ_TICK_O),
   .SAMPLE_O(SAMPLE_O), .BIT_START_O(BIT_START_O));
